// File: mbmc_consts.svh
`ifndef MBMC_CONSTS_SVH
`define MBMC_CONSTS_SVH
// bank count and decode window (32 Kbyte .. 256 Mbyte)
`define MBMC_NBANK     8
`define MBMC_CMP_LSB   15
`define MBMC_CMP_MSB   27
`define MBMC_BASE_W    17
`define MBMC_MASK_W    13
// wait states and boot bank defaults
`define MBMC_WS_MAX    5'h1E
`define MBMC_BOOT_WS   5'h0F
// refresh stacking limit and timer reset value
`define MBMC_PEND_MAX  3'h7
`define MBMC_TMR_RST   16'hFFFF
// four-beat burst, as a log2 beat count
`define MBMC_BURST_LOG 3'h2
// default column width of a dram row split
`define MBMC_COL_BITS  10
// dram depth codes: 0=64K, 1=128K, 2=256K .. 10=64M, 11=128M, 12=256M
`define MBMC_DEP_128K  4'h1
`define MBMC_DEP_64M   4'hA
`define MBMC_DEP_256M  4'hC
`endif

// File: mbmc_pkg.sv
package mbmc_pkg;
    // controller sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_ACC = 3'b001, ST_DRAS = 3'b010, ST_DCAS = 3'b011,
        ST_DCP  = 3'b100, ST_DPRE = 3'b101, ST_RCAS = 3'b110, ST_RRAS = 3'b111
    } mbmc_state_e;
    // port width codes
    typedef enum logic [1:0] {PS_32 = 2'b00, PS_8 = 2'b01, PS_16 = 2'b10} mbmc_ps_e;
    // transfer size codes
    typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10} mbmc_size_e;
endpackage

// File: mbmc_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
// one bank's configuration and its decode answer
interface mbmc_dec_if;
    logic [31:0] addr;     // access address
    logic [3:0]  attr;     // access type attributes
    logic        valid;    // bank enabled
    logic        dram;     // bank drives a row strobe
    logic        attr_en;  // attribute qualification on
    logic [3:0]  cfg_attr; // attribute to match
    logic [16:0] base;     // base address bits 31:15
    logic [12:0] mask;     // compare mask for bits 27:15
    logic [1:0]  ps;       // port width code
    logic [3:0]  depth;    // dram depth code
    logic        hit;      // bank matches
    logic        legal;    // configuration usable
    modport dec (input addr, attr, valid, dram, attr_en, cfg_attr, base, mask, ps, depth,
                 output hit, legal);
    modport ctl (output addr, attr, valid, dram, attr_en, cfg_attr, base, mask, ps, depth,
                 input hit, legal);
endinterface
`default_nettype wire

// File: mbmc_bank_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbmc_consts.svh"
module mbmc_bank_dec (
    // configuration in, decode out
    mbmc_dec_if.dec bus
);
    import mbmc_pkg::*;
    logic depth_ok; // depth allowed for this port width
    logic addr_ok;  // address inside block
    logic attr_ok;  // attributes agree or not checked

    // small depths only on byte ports, huge only on word ports
    always_comb begin
        if (bus.depth <= `MBMC_DEP_128K) begin
            depth_ok = (bus.ps == PS_8);
        end else if (bus.depth <= `MBMC_DEP_64M) begin
            depth_ok = 1'b1;
        end else if (bus.depth <= `MBMC_DEP_256M) begin
            depth_ok = (bus.ps == PS_32);
        end else begin
            depth_ok = 1'b0;
        end
    end

    // bits above 27 always compared, below 15 never
    assign addr_ok = (bus.addr[31:28] == bus.base[16:13]) &&
        (((bus.addr[`MBMC_CMP_MSB:`MBMC_CMP_LSB] ^ bus.base[12:0]) & bus.mask) == 13'h0000);
    assign attr_ok = !bus.attr_en || (bus.attr == bus.cfg_attr);
    assign bus.legal = !bus.dram || depth_ok;
    assign bus.hit = bus.valid && bus.legal && addr_ok && attr_ok;
endmodule // mbmc_bank_dec
`default_nettype wire

// File: mbmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbmc_consts.svh"
module mbmc_ctrl #(
    parameter int NBANK    = `MBMC_NBANK,
    parameter int COL_BITS = `MBMC_COL_BITS
) (
    // clock and resets
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     por,
    // processor request
    input  wire logic                     req,
    input  wire logic [31:0]              req_addr,
    input  wire logic                     req_wr,
    input  wire mbmc_pkg::mbmc_size_e     req_size,
    input  wire logic                     req_burst,
    input  wire logic [3:0]               req_attr,
    output logic                          ack,
    output logic                          err,
    output logic                          busy,
    // bank configuration, bank i in slice i
    input  wire logic [NBANK-1:0]         cfg_valid,
    input  wire logic [NBANK-1:0]         cfg_dram,
    input  wire logic [NBANK*17-1:0]      cfg_base,
    input  wire logic [NBANK*13-1:0]      cfg_mask,
    input  wire logic [NBANK*2-1:0]       cfg_ps,
    input  wire logic [NBANK*5-1:0]       cfg_ws,
    input  wire logic [NBANK-1:0]         cfg_attr_en,
    input  wire logic [NBANK*4-1:0]       cfg_attr,
    input  wire logic [NBANK*4-1:0]       cfg_depth,
    output logic [NBANK-1:0]              cfg_err,
    // dram strobe pattern
    input  wire logic [2:0]               cfg_rcd,
    input  wire logic [2:0]               cfg_cas,
    input  wire logic [2:0]               cfg_pre,
    // refresh control and status
    input  wire logic [15:0]              cfg_rfsh_period,
    input  wire logic                     cfg_rfsh_dis,
    output logic [2:0]                    rfsh_pend,
    // boot port width strap pin
    input  wire logic [1:0]               boot_ps,
    // memory pins
    output logic [31:0]                   mem_addr,
    output logic [NBANK-1:0]              sel_n,
    output logic [3:0]                    cas_n,
    output logic [3:0]                    be_n,
    output logic                          oe_n
);
    import mbmc_pkg::*;

    if (NBANK < 1 || NBANK > 8) begin : g_chk
        $error("mbmc_ctrl: NBANK must be 1 to 8");
    end
    if (COL_BITS < 4 || COL_BITS > 16) begin : g_chk_col
        $error("mbmc_ctrl: COL_BITS must be 4 to 16");
    end

    logic [NBANK-1:0] hit;          // per-bank decode answer
    logic [NBANK-1:0] legal;        // per-bank config usable
    logic [2:0]       hit_idx;      // winning bank
    logic             any_hit;      // some bank matched
    logic             boot_mode;    // bank zero answers everything
    logic [1:0]       boot_ps_m;    // strap sync, first stage
    logic [1:0]       boot_ps_s;    // strap sync, second stage
    logic [1:0]       boot_ps_q;    // strap caught at reset
    logic             boot_cap;     // reset seen on the previous edge
    logic [4:0]       sel_ws;       // winning bank wait states
    logic [1:0]       sel_ps;       // winning bank port width
    logic             sel_dram;     // winning bank is dram
    logic [15:0]      rf_timer;     // refresh interval counter
    logic             rf_tick;      // refresh interval elapsed
    logic             rf_go;        // refresh wanted now
    logic             rf_done;      // one refresh cycle finished
    logic             take;         // new access accepted

    mbmc_state_e state, next_state; // sequencer
    logic [5:0]  cnt, next_cnt;     // phase length counter
    logic [2:0]  bank, next_bank;   // bank of current access
    logic [31:0] addr, next_addr;   // address of current beat
    logic        wr, next_wr;       // write access
    logic [4:0]  ws, next_ws;       // wait states of current bank
    logic [1:0]  ps, next_ps;       // port width of current bank
    logic [1:0]  blb, next_blb;     // log2 bytes per beat
    logic [4:0]  beats, next_beats; // beats still to run
    logic [NBANK-1:0] next_sel_n;   // registered pin values
    logic [3:0]  next_cas_n;
    logic [3:0]  next_be_n;
    logic        next_oe_n;
    logic [31:0] next_mem_addr;
    logic        next_ack;
    logic        next_err;

    // one decoder per bank
    for (genvar i = 0; i < NBANK; i++) begin : g_bank
        mbmc_dec_if dif();
        assign dif.addr     = req_addr;
        assign dif.attr     = req_attr;
        assign dif.valid    = cfg_valid[i];
        assign dif.dram     = cfg_dram[i];
        assign dif.attr_en  = cfg_attr_en[i];
        assign dif.cfg_attr = cfg_attr[i*4 +: 4];
        assign dif.base     = cfg_base[i*17 +: 17];
        assign dif.mask     = cfg_mask[i*13 +: 13];
        assign dif.ps       = cfg_ps[i*2 +: 2];
        assign dif.depth    = cfg_depth[i*4 +: 4];
        // boot select catches every address until bank zero is set up
        assign hit[i]   = ((i == 0) && boot_mode) || dif.hit;
        assign legal[i] = dif.legal;
        mbmc_bank_dec u_dec (.bus(dif.dec));
    end

    // lowest numbered hit wins
    always_comb begin
        hit_idx = 3'h0;
        any_hit = 1'b0;
        for (int i = NBANK - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 3'(i);
                any_hit = 1'b1;
            end
        end
    end

    // winning bank attributes, boot bank overrides bank zero
    always_comb begin
        if (boot_mode && hit_idx == 3'h0) begin
            sel_ws   = `MBMC_BOOT_WS;
            sel_ps   = boot_ps_q;
            sel_dram = 1'b0;
        end else begin
            sel_ws   = cfg_ws[hit_idx*5 +: 5];
            sel_ps   = cfg_ps[hit_idx*2 +: 2];
            sel_dram = cfg_dram[hit_idx];
        end
        if (sel_ws > `MBMC_WS_MAX) begin
            sel_ws = `MBMC_WS_MAX; // clip out-of-range settings
        end
    end

    // byte lanes of one beat; narrow ports sit on the low lanes
    function automatic logic [3:0] lanes(input logic [1:0] p, input logic [1:0] lb,
                                         input logic [1:0] a);
        logic [3:0] l;
        l = 4'h1;
        case (p)
            PS_8:    l = 4'h1;
            PS_16:   l = (lb == 2'h0) ? (a[0] ? 4'h2 : 4'h1) : 4'h3;
            default: l = (lb == 2'h2) ? 4'hF : (lb == 2'h1) ? (a[1] ? 4'hC : 4'h3)
                                                            : (4'h1 << a);
        endcase
        return l;
    endfunction

    // log2 of port bytes
    function automatic logic [1:0] plog(input logic [1:0] p);
        return (p == PS_8) ? 2'h0 : (p == PS_16) ? 2'h1 : 2'h2;
    endfunction

    // strap pin: two stages, caught while reset holds
    always_ff @(posedge sys_clk) begin
        boot_ps_m <= boot_ps;
        boot_ps_s <= boot_ps_m;
    end

    // strap taken through reset and one edge past it: the sync needs three edges
    always_ff @(posedge sys_clk) begin
        boot_cap <= por || rst;
        if (por || rst || boot_cap) begin
            boot_ps_q <= boot_ps_s;
        end
    end

    // boot mode ends once software enables bank zero
    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            boot_mode <= 1'b1;
        end else if (cfg_valid[0]) begin
            boot_mode <= 1'b0;
        end
    end

    // refresh timer runs on power-on reset only, so it survives rst
    assign rf_tick = (rf_timer == 16'h0000) && !cfg_rfsh_dis;
    always_ff @(posedge sys_clk) begin
        if (por) begin
            rf_timer <= `MBMC_TMR_RST;
        end else if (rf_timer == 16'h0000) begin
            rf_timer <= cfg_rfsh_period;
        end else begin
            rf_timer <= rf_timer - 16'h0001;
        end
    end

    // pending count: a tick arriving with a finish is not lost
    always_ff @(posedge sys_clk) begin
        if (por || cfg_rfsh_dis) begin
            rfsh_pend <= 3'h0;
        end else if (rf_tick && !rf_done && rfsh_pend != `MBMC_PEND_MAX) begin
            rfsh_pend <= rfsh_pend + 3'h1;
        end else if (rf_done && !rf_tick) begin
            rfsh_pend <= rfsh_pend - 3'h1;
        end
    end

    assign rf_go = (rfsh_pend != 3'h0) && !cfg_rfsh_dis;
    assign take  = (state == ST_IDLE) && req && !rst && !rf_go;

    // sequencer next state
    always_comb begin
        logic [1:0] lb;
        logic [2:0] blog;
        lb         = req_size;
        blog       = 3'h0;
        next_state = state;
        next_cnt   = cnt;
        next_bank  = bank;
        next_addr  = addr;
        next_wr    = wr;
        next_ws    = ws;
        next_ps    = ps;
        next_blb   = blb;
        next_beats = beats;
        next_ack   = 1'b0;
        next_err   = 1'b0;
        rf_done    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (rf_go) begin
                    next_state = ST_RCAS;
                    next_cnt   = {3'h0, cfg_rcd};
                end else if (take && !any_hit) begin
                    next_ack = 1'b1;
                    next_err = 1'b1;
                end else if (take) begin
                    next_bank = hit_idx;
                    next_addr = req_addr;
                    next_wr   = req_wr;
                    next_ws   = sel_ws;
                    next_ps   = sel_ps;
                    next_blb  = (lb < plog(sel_ps)) ? lb : plog(sel_ps);
                    blog      = {1'b0, lb - next_blb} + (req_burst ? `MBMC_BURST_LOG : 3'h0);
                    next_beats = 5'((5'h01 << blog) - 5'h01);
                    next_state = sel_dram ? ST_DRAS : ST_ACC;
                    next_cnt   = sel_dram ? {3'h0, cfg_rcd} : {1'b0, sel_ws};
                end
            end
            ST_ACC: begin
                if (rst) begin
                    next_state = ST_IDLE;
                end else if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else if (beats == 5'h00) begin
                    next_state = ST_IDLE;
                    next_ack   = 1'b1;
                end else begin
                    next_addr  = addr + (32'h0000_0001 << blb);
                    next_beats = beats - 5'h01;
                    next_cnt   = {1'b0, ws};
                end
            end
            ST_DRAS: begin
                if (rst) begin
                    next_state = ST_DPRE;
                    next_cnt   = {3'h0, cfg_pre};
                end else if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else begin
                    next_state = ST_DCAS;
                    next_cnt   = {3'h0, cfg_cas} + {1'b0, ws};
                end
            end
            ST_DCAS: begin
                if (rst || (cnt == 6'h00 && beats == 5'h00)) begin
                    next_state = ST_DPRE;
                    next_cnt   = {3'h0, cfg_pre};
                    next_ack   = !rst;
                end else if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else begin
                    next_state = ST_DCP;
                    next_addr  = addr + (32'h0000_0001 << blb);
                    next_beats = beats - 5'h01;
                end
            end
            ST_DCP: begin
                next_state = rst ? ST_DPRE : ST_DCAS;
                next_cnt   = rst ? {3'h0, cfg_pre} : {3'h0, cfg_cas} + {1'b0, ws};
            end
            ST_RCAS: begin
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else begin
                    next_state = ST_RRAS;
                    next_cnt   = {3'h0, cfg_cas};
                end
            end
            ST_RRAS: begin
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else begin
                    next_state = ST_DPRE;
                    next_cnt   = {3'h0, cfg_pre};
                    rf_done    = 1'b1;
                end
            end
            ST_DPRE: begin
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // pin values follow the state being entered
    always_comb begin
        next_sel_n    = '1;
        next_cas_n    = 4'hF;
        next_be_n     = 4'hF;
        next_oe_n     = 1'b1;
        next_mem_addr = mem_addr;
        case (next_state)
            ST_ACC: begin
                next_sel_n[next_bank] = 1'b0;
                next_be_n     = ~lanes(next_ps, next_blb, next_addr[1:0]);
                next_oe_n     = next_wr;
                next_mem_addr = next_addr;
            end
            ST_DRAS, ST_DCP: begin
                next_sel_n[next_bank] = 1'b0;
                next_mem_addr = next_addr >> COL_BITS;
            end
            ST_DCAS: begin
                next_sel_n[next_bank] = 1'b0;
                next_cas_n    = ~lanes(next_ps, next_blb, next_addr[1:0]);
                next_be_n     = next_wr ? next_cas_n : 4'hF;
                next_oe_n     = next_wr;
                next_mem_addr = next_addr & ((32'h0000_0001 << COL_BITS) - 32'h0000_0001);
            end
            ST_RCAS: next_cas_n = 4'h0;
            ST_RRAS: begin
                next_cas_n = 4'h0;
                next_sel_n = ~(cfg_dram & cfg_valid & legal);
            end
            default: next_sel_n = '1;
        endcase
    end

    // sequencer registers; power-on only, so refresh rides through rst
    always_ff @(posedge sys_clk) begin
        if (por) begin
            state <= ST_IDLE;
            cnt   <= 6'h00;
            bank  <= 3'h0;
            addr  <= 32'h0000_0000;
            wr    <= 1'b0;
            ws    <= 5'h00;
            ps    <= PS_32;
            blb   <= 2'h0;
            beats <= 5'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            bank  <= next_bank;
            addr  <= next_addr;
            wr    <= next_wr;
            ws    <= next_ws;
            ps    <= next_ps;
            blb   <= next_blb;
            beats <= next_beats;
        end
    end

    // output registers
    always_ff @(posedge sys_clk) begin
        if (por) begin
            sel_n    <= '1;
            cas_n    <= 4'hF;
            be_n     <= 4'hF;
            oe_n     <= 1'b1;
            mem_addr <= 32'h0000_0000;
            ack      <= 1'b0;
            err      <= 1'b0;
            busy     <= 1'b0;
            cfg_err  <= '0;
        end else begin
            sel_n    <= next_sel_n;
            cas_n    <= next_cas_n;
            be_n     <= next_be_n;
            oe_n     <= next_oe_n;
            mem_addr <= next_mem_addr;
            ack      <= next_ack;
            err      <= next_err;
            busy     <= (next_state != ST_IDLE);
            cfg_err  <= cfg_valid & ~legal;
        end
    end

    // checks
    sequence s_take_sram0;
        take && any_hit && !sel_dram && sel_ws == 5'h00 && !req_burst && req_size == SZ_BYTE;
    endsequence
    sequence s_cbr;
        state == ST_RCAS ##1 state == ST_RRAS;
    endsequence

    one_select_a: assert property (@(posedge sys_clk) disable iff (por)
        state != ST_RRAS |-> $onehot0(~sel_n)) else $error("more than one select low");
    sram_two_a: assert property (@(posedge sys_clk) disable iff (por)
        s_take_sram0 |=> state == ST_ACC && sel_n[bank] == 1'b0 ##1 ack && !busy)
        else $error("zero-wait access not two clocks");
    wait_hold_a: assert property (@(posedge sys_clk) disable iff (por || rst)
        state == ST_ACC && cnt != 6'h00 |=> state == ST_ACC && !ack && sel_n == $past(sel_n))
        else $error("wait state cut short");
    pend_cap_a: assert property (@(posedge sys_clk) disable iff (por)
        rfsh_pend == `MBMC_PEND_MAX && rf_tick && !rf_done |=> rfsh_pend == `MBMC_PEND_MAX)
        else $error("pending refresh count overflowed");
    rfsh_off_a: assert property (@(posedge sys_clk) disable iff (por)
        cfg_rfsh_dis && state == ST_IDLE |=> state != ST_RCAS) else $error("refresh while off");
    cbr_order_a: assert property (@(posedge sys_clk) disable iff (por)
        s_cbr |-> cas_n == 4'h0 && $past(cas_n) == 4'h0 && $past(sel_n) == '1)
        else $error("ras before cas");
    page_keep_a: assert property (@(posedge sys_clk) disable iff (por || rst)
        state == ST_DCP |-> sel_n[bank] == 1'b0 && cas_n == 4'hF ##1 sel_n[bank] == 1'b0)
        else $error("row closed inside burst");
    rfsh_first_a: assert property (@(posedge sys_clk) disable iff (por)
        state == ST_IDLE && rf_go |=> state == ST_RCAS) else $error("refresh lost priority");
    miss_none_a: assert property (@(posedge sys_clk) disable iff (por)
        take && !any_hit |=> ack && err && sel_n == '1) else $error("miss drove a select");
    rst_rfsh_a: assert property (@(posedge sys_clk) disable iff (por)
        rst && state == ST_RCAS && cnt == 6'h00 |=> state == ST_RRAS)
        else $error("reset stopped refresh");
endmodule // mbmc_ctrl
`default_nettype wire

// File: mbmc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side memory: watches strobes, counts cas-before-ras refreshes
module mbmc_mem_model (
    // memory pins
    input  wire logic       sys_clk,
    input  wire logic [7:0] sel_n,
    input  wire logic [3:0] cas_n,
    // refreshes seen
    output int              rfsh_seen
);
    logic cbr = 1'b0; // cas low while no select low
    int   seen = 0;   // refresh tally
    assign rfsh_seen = seen;
    // a row strobe that follows a lone cas is a refresh
    always @(posedge sys_clk) begin
        if (cbr && sel_n != 8'hFF) seen <= seen + 1;
        cbr <= (cas_n != 4'hF) && (sel_n == 8'hFF);
    end
endmodule // mbmc_mem_model
`default_nettype wire

// File: multi_bank_memory_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module multi_bank_memory_controller_tb;
    import mbmc_pkg::*;
    // stimulus, all set at time zero
    logic         sys_clk = 1'b0, rst = 1'b1, por = 1'b1, req = 1'b0, req_wr = 1'b0;
    logic         req_burst = 1'b0, cfg_rfsh_dis = 1'b0, ack, err, busy, oe_n, acc_oe;
    logic [31:0]  req_addr = 32'h0, cfg_attr = '0, cfg_depth = {8{4'h4}};
    logic [31:0]  mem_addr, acc_ma;
    mbmc_size_e   req_size = SZ_WORD;
    logic [3:0]   req_attr = 4'h0, cas_n, be_n, acc_be;
    logic [7:0]   cfg_valid = 8'h00, cfg_dram = 8'h00, cfg_attr_en = 8'h00, sel_n, acc_sel;
    logic [7:0]   cfg_err;
    logic [135:0] cfg_base = '0;
    logic [103:0] cfg_mask = '1; // compare every decode bit
    logic [15:0]  cfg_ps = '0, cfg_rfsh_period = 16'h0009;
    logic [39:0]  cfg_ws = '0;
    logic [2:0]   cfg_rcd = 3'h0, cfg_cas = 3'h0, cfg_pre = 3'h0, rfsh_pend;
    logic [1:0]   boot_ps = 2'h0;
    int           err_total = 0, samples_checked = 0, rfsh_seen, n, r0;

    always #12.5 sys_clk = ~sys_clk; // 40 MHz

    mbmc_ctrl u_mbmc_ctrl (.sys_clk, .rst, .por, .req, .req_addr, .req_wr, .req_size,
        .req_burst, .req_attr, .ack, .err, .busy, .cfg_valid, .cfg_dram, .cfg_base,
        .cfg_mask, .cfg_ps, .cfg_ws, .cfg_attr_en, .cfg_attr, .cfg_depth, .cfg_err,
        .cfg_rcd, .cfg_cas, .cfg_pre, .cfg_rfsh_period, .cfg_rfsh_dis, .rfsh_pend,
        .boot_ps, .mem_addr, .sel_n, .cas_n, .be_n, .oe_n);
    mbmc_mem_model u_mbmc_mem_model (.sys_clk, .sel_n, .cas_n, .rfsh_seen);

    // one access: count cycles to ack, gather sram selects, check err
    task automatic acc(input logic [31:0] a, input logic [3:0] at, input logic bst,
                       input int exp_n, input logic [7:0] exp_sel, input logic exp_err);
        @(negedge sys_clk);
        req_addr = a;
        req_attr = at;
        req_burst = bst;
        req = 1'b1;
        n = 0;
        acc_sel = 8'hFF;
        acc_be = 'x;
        acc_oe = 1'bx;
        acc_ma = 'x;
        // dram selects masked: a refresh before take is not this access
        while (ack !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
            acc_sel &= sel_n | cfg_dram;
            // lanes, strobe and address of the last sram beat
            if ((sel_n | cfg_dram) != 8'hFF) begin
                acc_be = be_n;
                acc_oe = oe_n;
                acc_ma = mem_addr;
            end
        end
        req = 1'b0; // dropped in the ack cycle
        `CHK(ack, 1'b1)
        if (exp_n > 0) `CHK(n, exp_n)
        `CHK(acc_sel, exp_sel)
        `CHK(err, exp_err)
    endtask

    // bank setup: base, width code, wait states
    task automatic bank(input int i, input logic [16:0] b, input logic [1:0] p,
                        input logic [4:0] w);
        cfg_base[i*17+:17] = b;
        cfg_ps[i*2+:2] = p;
        cfg_ws[i*5+:5] = w;
        cfg_valid[i] = 1'b1;
    endtask

    // verdict, shared by tests and watchdog
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        por = 1'b0;
        acc(32'h1234_5678, 4'h0, 1'b0, 17, 8'hFE, 1'b0);
        $display("test boot done");
        bank(0, 17'h1FFFF, 2'h0, 5'h00);
        bank(1, 17'h00002, 2'h0, 5'h00);
        bank(2, 17'h00004, 2'h0, 5'h03);
        bank(3, 17'h00008, 2'h0, 5'h00);
        bank(4, 17'h0000C, 2'h1, 5'h00);
        bank(5, 17'h00002, 2'h0, 5'h00);
        bank(6, 17'h00010, 2'h1, 5'h1E);
        bank(7, 17'h00014, 2'h0, 5'h00);
        cfg_dram[3] = 1'b1;
        cfg_attr_en[7] = 1'b1;
        cfg_attr[31:28] = 4'h5;
        acc(32'h0001_0000, 4'h0, 1'b0, 2, 8'hFD, 1'b0);
        `CHK(busy, 1'b0)
        `CHK(acc_oe, 1'b0)
        req_size = SZ_BYTE;
        acc(32'h0001_0001, 4'h0, 1'b0, 2, 8'hFD, 1'b0);
        `CHK(acc_be, 4'hD)
        req_size = SZ_WORD;
        req_wr = 1'b1;
        acc(32'h0002_0004, 4'h0, 1'b0, 5, 8'hFB, 1'b0);
        `CHK(acc_oe, 1'b1)
        `CHK(acc_be, 4'h0)
        req_wr = 1'b0;
        acc(32'h0003_0000, 4'h0, 1'b0, 1, 8'hFF, 1'b1);
        acc(32'h0006_0000, 4'h0, 1'b0, 5, 8'hEF, 1'b0);
        `CHK(acc_ma, 32'h0006_0003)
        `CHK(acc_be, 4'hE)
        acc(32'h000A_0000, 4'h3, 1'b0, 1, 8'hFF, 1'b1);
        acc(32'h000A_0000, 4'h5, 1'b0, 2, 8'h7F, 1'b0);
        // four-beat page-mode burst to the dram bank
        acc(32'h0004_0000, 4'h0, 1'b1, 9, 8'hFF, 1'b0);
        `CHK(busy, 1'b1)
        cfg_depth[15:12] = 4'h1;
        @(negedge sys_clk);
        `CHK(cfg_err, 8'h08)
        cfg_depth[15:12] = 4'h4;
        $display("test decode done");
        // timer starts from its reset value, so the first tick is far off
        n = 0;
        while (rfsh_seen == 0 && n < 70000) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(rfsh_seen > 0, 1'b1)
        acc(32'h0008_0000, 4'h0, 1'b1, 0, 8'hBF, 1'b0);
        `CHK(rfsh_pend, 3'h7)
        r0 = rfsh_seen;
        repeat (40) @(negedge sys_clk);
        `CHK(rfsh_seen - r0 >= 7, 1'b1)
        rst = 1'b1;
        r0 = rfsh_seen;
        repeat (50) @(negedge sys_clk);
        `CHK(rfsh_seen - r0 >= 4, 1'b1)
        rst = 1'b0;
        cfg_rfsh_dis = 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK(rfsh_pend, 3'h0)
        r0 = rfsh_seen;
        repeat (40) @(negedge sys_clk);
        `CHK(rfsh_seen, r0)
        $display("test refresh done");
        final_report;
    end

    // watchdog: boot wait, refresh timer wrap and long burst fit well inside
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_total++;
        final_report;
    end
endmodule // multi_bank_memory_controller_tb
`default_nettype wire
